//--- core/adc_channel_calibration_regs.sv
// register slice: channel 0 gain, channel 1 input select, offset and gain
// assumes a one-cycle strobe port; read data one cycle after the strobe
//
// Notes on behaviour
// - channel 0 upper gain register holds gain bits 23:8, full RW
// - gain value is unsigned, 0 to just under 2.0
// - gain upper resets to 8000h, lower to 0000h, unity gain
// - gain lower register: bits 15:8 hold value 7:0, low byte reads 0
// - channel 1 config bits 5:3 read as zero
// - select field 1:0 picks pins, short, positive or negative test
// - channel 1 offset upper holds bits 23:8, value is signed
// - offset lower: bits 15:8 hold value 7:0, low byte reads 0
// - offset registers reset to 0000h
// - channel 1 config resets to 0000h, normal pins
`timescale 1ns/1ps
`default_nettype none
module adc_channel_calibration_regs
   import cal_regs_pkg::*;
(
   input  wire logic              clk,              // 200 MHz clock
   input  wire logic              sys_rst,          // async reset, high
   input  wire logic [ADDR_W-1:0] reg_addr,         // word address
   input  wire logic [DATA_W-1:0] reg_wdata,        // write data
   input  wire logic              reg_wr,           // write strobe
   input  wire logic              reg_rd,           // read strobe
   output logic      [DATA_W-1:0] reg_rdata,        // read data, next cycle
   output logic      [CAL_W-1:0]  ch0_gain_value,   // unsigned gain
   output logic      [CAL_W-1:0]  ch1_gain_value,   // unsigned gain
   output logic      [CAL_W-1:0]  ch1_offset_value, // signed offset
   output input_sel_t             ch1_input_select, // modulator input
   output logic                   ch1_pins_connect, // normal pin pair
   output logic                   ch1_inputs_short, // inputs shorted
   output logic                   ch1_test_pos,     // positive test
   output logic                   ch1_test_neg      // negative test
);
   // ******************************
   // request decode
   // ******************************
   reg_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   logic wr_g0h, wr_g0l, wr_o1h, wr_o1l, wr_g1h, wr_g1l, wr_cfg1, wr_cfg2;
   assign wr_g0h  = req.wr && req.addr == CH0_GAIN_CAL_HIGH_OFS;
   assign wr_g0l  = req.wr && req.addr == CH0_GAIN_CAL_LOW_OFS;
   assign wr_cfg1 = req.wr && req.addr == CH1_INPUT_CONFIG_OFS;
   assign wr_o1h  = req.wr && req.addr == CH1_OFFSET_CAL_HIGH_OFS;
   assign wr_o1l  = req.wr && req.addr == CH1_OFFSET_CAL_LOW_OFS;
   assign wr_g1h  = req.wr && req.addr == CH1_GAIN_CAL_HIGH_OFS;
   assign wr_g1l  = req.wr && req.addr == CH1_GAIN_CAL_LOW_OFS;
   assign wr_cfg2 = req.wr && req.addr == CH2_INPUT_CONFIG_OFS;

   // ******************************
   // calibration pairs
   // ******************************
   logic [15:0] g0h_rd, g0l_rd, o1h_rd, o1l_rd, g1h_rd, g1l_rd;
   cal_word_t   g0_cal, o1_cal, g1_cal;

   cal_pair #(.HIGH_RST(GAIN_HIGH_RST)) u_ch0_gain (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_high (wr_g0h),
      .wr_low  (wr_g0l),
      .wdata   (req.wdata),
      .high_rd (g0h_rd),
      .low_rd  (g0l_rd),
      .cal     (g0_cal)
   );

   cal_pair #(.HIGH_RST(ZERO_RST)) u_ch1_offset (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_high (wr_o1h),
      .wr_low  (wr_o1l),
      .wdata   (req.wdata),
      .high_rd (o1h_rd),
      .low_rd  (o1l_rd),
      .cal     (o1_cal)
   );

   cal_pair #(.HIGH_RST(GAIN_HIGH_RST)) u_ch1_gain (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_high (wr_g1h),
      .wr_low  (wr_g1l),
      .wdata   (req.wdata),
      .high_rd (g1h_rd),
      .low_rd  (g1l_rd),
      .cal     (g1_cal)
   );

   // ******************************
   // config registers
   // ******************************
   // reserved writable bits are stored as written; 5:3 never stored
   logic [15:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d;

   always_comb
   begin
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      if (wr_cfg1)
         cfg1_d = req.wdata & CFG_WRITE_MASK;
      if (wr_cfg2)
         cfg2_d = req.wdata & CFG_WRITE_MASK;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg1_q <= ZERO_RST;
         cfg2_q <= ZERO_RST;
      end
      else
      begin
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
      end
   end

   // ******************************
   // read path
   // ******************************
   logic [15:0] rdata_q, rdata_d;

   always_comb
   begin
      rdata_d = ZERO_RST;
      if (req.rd)
      begin
         if (req.addr == CH0_GAIN_CAL_HIGH_OFS)
            rdata_d = g0h_rd;
         else if (req.addr == CH0_GAIN_CAL_LOW_OFS)
            rdata_d = g0l_rd;
         else if (req.addr == CH1_INPUT_CONFIG_OFS)
            rdata_d = cfg1_q;
         else if (req.addr == CH1_OFFSET_CAL_HIGH_OFS)
            rdata_d = o1h_rd;
         else if (req.addr == CH1_OFFSET_CAL_LOW_OFS)
            rdata_d = o1l_rd;
         else if (req.addr == CH1_GAIN_CAL_HIGH_OFS)
            rdata_d = g1h_rd;
         else if (req.addr == CH1_GAIN_CAL_LOW_OFS)
            rdata_d = g1l_rd;
         else if (req.addr == CH2_INPUT_CONFIG_OFS)
            rdata_d = cfg2_q;
         else
            rdata_d = ZERO_RST;
      end
   end

   // ******************************
   // outputs, all registered
   // ******************************
   input_sel_t sel_d, sel_q;
   logic [3:0] dec_d, dec_q;
   logic [CAL_W-1:0] g0_q, g1_q, o1_q;

   always_comb
   begin
      sel_d = input_sel_t'(cfg1_d[1:0]);
      case (sel_d)
         SEL_NORMAL_PINS: dec_d = 4'h1;
         SEL_SHORTED:     dec_d = 4'h2;
         SEL_POS_TEST:    dec_d = 4'h4;
         default:         dec_d = 4'h8;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_q <= ZERO_RST;
         sel_q   <= SEL_NORMAL_PINS;
         dec_q   <= 4'h1;
         g0_q    <= {GAIN_HIGH_RST, LOW_BYTE_RST};
         g1_q    <= {GAIN_HIGH_RST, LOW_BYTE_RST};
         o1_q    <= {ZERO_RST, LOW_BYTE_RST};
      end
      else
      begin
         rdata_q <= rdata_d;
         sel_q   <= sel_d;
         dec_q   <= dec_d;
         // hold while a half is pending, so no torn value leaks out
         g0_q    <= g0_cal.valid ? g0_cal.value : g0_q;
         g1_q    <= g1_cal.valid ? g1_cal.value : g1_q;
         o1_q    <= o1_cal.valid ? o1_cal.value : o1_q;
      end
   end

   assign reg_rdata        = rdata_q;
   assign ch0_gain_value   = g0_q;
   assign ch1_gain_value   = g1_q;
   assign ch1_offset_value = o1_q;
   assign ch1_input_select = sel_q;
   assign ch1_pins_connect = dec_q[0];
   assign ch1_inputs_short = dec_q[1];
   assign ch1_test_pos     = dec_q[2];
   assign ch1_test_neg     = dec_q[3];
endmodule
`default_nettype wire

//--- core/cal_regs_pkg.sv
// constants and carrier types for the channel calibration register slice
// assumes a 16-bit register port with word addresses as printed
package cal_regs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CAL_W  = 24;

   // ******************************
   // register offsets
   // ******************************
   localparam logic [7:0] CH0_GAIN_CAL_HIGH_OFS   = 8'h0C;
   localparam logic [7:0] CH0_GAIN_CAL_LOW_OFS    = 8'h0D;
   localparam logic [7:0] CH1_INPUT_CONFIG_OFS    = 8'h0E;
   localparam logic [7:0] CH1_OFFSET_CAL_HIGH_OFS = 8'h0F;
   localparam logic [7:0] CH1_OFFSET_CAL_LOW_OFS  = 8'h10;
   localparam logic [7:0] CH1_GAIN_CAL_HIGH_OFS   = 8'h11;
   localparam logic [7:0] CH1_GAIN_CAL_LOW_OFS    = 8'h12;
   localparam logic [7:0] CH2_INPUT_CONFIG_OFS    = 8'h13;

   // ******************************
   // reset values and field layout
   // ******************************
   localparam logic [15:0] GAIN_HIGH_RST   = 16'h8000;
   localparam logic [15:0] ZERO_RST        = 16'h0000;
   localparam logic [7:0]  LOW_BYTE_RST    = 8'h00;
   localparam int          LOW_FIELD_LSB   = 8;
   localparam int          CFG_RO_MSB      = 5;
   localparam int          CFG_RO_LSB      = 3;
   localparam logic [15:0] CFG_WRITE_MASK  = 16'hFFC7;

   typedef enum logic [1:0] {
      SEL_NORMAL_PINS,
      SEL_SHORTED,
      SEL_POS_TEST,
      SEL_NEG_TEST
   } input_sel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic [CAL_W-1:0] value;
      logic             valid;
   } cal_word_t;
endpackage

//--- core/cal_pair.sv
// one 24-bit calibration value split over an upper word and a lower byte
// assumes writes arrive as single-cycle strobes on the block clock
`timescale 1ns/1ps
`default_nettype none
module cal_pair
   import cal_regs_pkg::*;
#(
   parameter logic [15:0] HIGH_RST = 16'h0000
)(
   input  wire logic        clk,        // block clock
   input  wire logic        sys_rst,    // async reset, active high
   input  wire logic        wr_high,    // write upper word
   input  wire logic        wr_low,     // write lower register
   input  wire logic [15:0] wdata,      // write data
   output logic      [15:0] high_rd,    // upper register readback
   output logic      [15:0] low_rd,     // lower register readback
   output var cal_word_t    cal         // assembled value
);
   logic [15:0]     high_q, high_d;
   logic [7:0]      low_q, low_d;
   logic            pend_hi_q, pend_hi_d;
   logic            pend_lo_q, pend_lo_d;
   logic [CAL_W-1:0] val_q, val_d;

   always_comb
   begin
      high_d    = high_q;
      low_d     = low_q;
      pend_hi_d = pend_hi_q;
      pend_lo_d = pend_lo_q;
      val_d     = val_q;
      if (wr_high)
      begin
         high_d    = wdata;
         pend_hi_d = 1'b1;
      end
      if (wr_low)
      begin
         low_d     = wdata[15:LOW_FIELD_LSB];
         pend_lo_d = 1'b1;
      end
      // commit only once both halves are fresh, to avoid a torn value
      if (pend_hi_d && pend_lo_d)
      begin
         val_d     = {high_d, low_d};
         pend_hi_d = 1'b0;
         pend_lo_d = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         high_q    <= HIGH_RST;
         low_q     <= LOW_BYTE_RST;
         pend_hi_q <= 1'b0;
         pend_lo_q <= 1'b0;
         val_q     <= {HIGH_RST, LOW_BYTE_RST};
      end
      else
      begin
         high_q    <= high_d;
         low_q     <= low_d;
         pend_hi_q <= pend_hi_d;
         pend_lo_q <= pend_lo_d;
         val_q     <= val_d;
      end
   end

   assign high_rd   = high_q;
   assign low_rd    = {low_q, LOW_BYTE_RST};
   assign cal = '{value: val_q, valid: ~(pend_hi_q | pend_lo_q)};
endmodule
`default_nettype wire

//--- dv/cal_regs_checker_assertions.sv
// concurrent checks on the ports of the calibration register slice
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
`default_nettype none
module cal_regs_checker
   import cal_regs_pkg::*;
(
   input wire logic              clk,              // block clock
   input wire logic              sys_rst,          // async reset
   input wire logic [ADDR_W-1:0] reg_addr,         // word address
   input wire logic [DATA_W-1:0] reg_wdata,        // write data
   input wire logic              reg_wr,           // write strobe
   input wire logic              reg_rd,           // read strobe
   input wire logic [DATA_W-1:0] reg_rdata,        // read data
   input wire logic [CAL_W-1:0]  ch0_gain_value,   // gain value
   input wire logic [CAL_W-1:0]  ch1_offset_value, // offset value
   input wire input_sel_t        ch1_input_select, // select
   input wire logic              ch1_pins_connect, // decode
   input wire logic              ch1_inputs_short, // decode
   input wire logic              ch1_test_pos,     // decode
   input wire logic              ch1_test_neg      // decode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ******************************
   // port relations
   // ******************************
   a_cfg_ro_zero: assert property (
      reg_rd && reg_addr == CH1_INPUT_CONFIG_OFS |=> reg_rdata[5:3] == 3'h0)
      else $error("config reserved bits read nonzero");
   a_low_byte_zero: assert property (
      reg_rd && (reg_addr == CH0_GAIN_CAL_LOW_OFS || reg_addr ==
      CH1_OFFSET_CAL_LOW_OFS || reg_addr == CH1_GAIN_CAL_LOW_OFS)
      |=> reg_rdata[7:0] == 8'h00) else $error("low byte reads nonzero");
   a_sel_onehot: assert property (
      {ch1_test_neg, ch1_test_pos, ch1_inputs_short, ch1_pins_connect}
      == 4'h1 << ch1_input_select) else $error("select decode wrong");
   a_sel_write: assert property (
      reg_wr && reg_addr == CH1_INPUT_CONFIG_OFS
      |=> ch1_input_select == $past(reg_wdata[1:0])) else $error("sel lost");
   a_cfg_readback: assert property (
      reg_wr && reg_addr == CH1_INPUT_CONFIG_OFS ##1 reg_rd && reg_addr ==
      CH1_INPUT_CONFIG_OFS |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
      else $error("select readback wrong");
   a_gain_high_rb: assert property (
      reg_wr && reg_addr == CH0_GAIN_CAL_HIGH_OFS ##1 reg_rd && reg_addr ==
      CH0_GAIN_CAL_HIGH_OFS |=> reg_rdata == $past(reg_wdata, 2))
      else $error("gain upper readback wrong");
   a_gain_commit: assert property (
      !$past(reg_wr, 2) |-> $stable(ch0_gain_value))
      else $error("gain value moved without write");
   a_offset_commit: assert property (
      !$past(reg_wr, 2) |-> $stable(ch1_offset_value))
      else $error("offset value moved without write");
endmodule

bind adc_channel_calibration_regs cal_regs_checker chk_u (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ch0_gain_value(ch0_gain_value),
   .ch1_offset_value(ch1_offset_value),
   .ch1_input_select(ch1_input_select),
   .ch1_pins_connect(ch1_pins_connect),
   .ch1_inputs_short(ch1_inputs_short),
   .ch1_test_pos(ch1_test_pos), .ch1_test_neg(ch1_test_neg));
`default_nettype wire

//--- dv/adc_channel_calibration_regs_test.sv
// self-checking bench for the calibration register slice
// assumes the package, the design and the checker compile ahead of it
`timescale 1ns/1ps
`default_nettype none
module adc_channel_calibration_regs_test
   import cal_regs_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata, rd_exp, rd_want;
   logic        rd_taken = 1'b0;
   logic [23:0] g0, g1, of1;
   input_sel_t  sel;
   logic        pc, sh, tp, tn;
   int          mismatches = 0;
   int          checks = 0;
   logic [15:0] rst_tab [8] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000,
                                16'h0000, 16'h8000, 16'h0000, 16'h0000};
   logic [15:0] msk_tab [8] = '{16'hFFFF, 16'hFF00, 16'h0003, 16'hFFFF,
                                16'hFF00, 16'hFFFF, 16'hFF00, 16'h0003};

   always #2.5 clk = ~clk;

   adc_channel_calibration_regs dut_u (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ch0_gain_value(g0), .ch1_gain_value(g1),
      .ch1_offset_value(of1), .ch1_input_select(sel),
      .ch1_pins_connect(pc), .ch1_inputs_short(sh),
      .ch1_test_pos(tp), .ch1_test_neg(tn));

   // ******************************
   // bus tasks and compares
   // ******************************
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: word got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp24(input logic [23:0] g, input logic [23:0] e);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: value got %h expected %h", $time, g, e);
      end
   endtask
   // strobes stay up until the next task, so calls run back to back
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      rd_exp <= e;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // read data stand one cycle only, so judge them mid-cycle
   always @(posedge clk)
   begin
      rd_taken <= reg_rd;
      rd_want <= rd_exp;
   end
   always @(negedge clk)
      if (rd_taken === 1'b1)
         cmp16(reg_rdata, rd_want);

   // ******************************
   // scenarios
   // ******************************
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rd(CH0_GAIN_CAL_HIGH_OFS + 8'(i), rst_tab[i]);
      rd(8'h0B, 16'h0000);
      rd(8'h14, 16'h0000);
      idle(2);
      @(negedge clk);
      cmp24(g0, 24'h800000);
      cmp24(of1, 24'h000000);
      cmp24(g1, 24'h800000);
      cmp16({10'h0, sel, tn, tp, sh, pc}, 16'h0001);
      @(posedge clk);
   endtask
   task automatic t_mask;
      // config words keep reserved writable bits zero, 5:3 set
      for (int i = 0; i < 8; i++)
         wr(CH0_GAIN_CAL_HIGH_OFS + 8'(i),
            (i == 2 || i == 7) ? 16'h003B : 16'hFFFF);
      wr(8'h0B, 16'hFFFF);
      for (int i = 0; i < 8; i++)
         rd(CH0_GAIN_CAL_HIGH_OFS + 8'(i), msk_tab[i]);
      rd(8'h0B, 16'h0000);
      idle(2);
      @(negedge clk);
      cmp24(g0, 24'hFFFFFF);
      cmp24(of1, 24'hFFFFFF);
      @(posedge clk);
   endtask
   task automatic t_pair;
      wr(CH0_GAIN_CAL_HIGH_OFS, 16'h1234);
      idle(3);
      @(negedge clk);
      cmp24(g0, 24'hFFFFFF);
      @(posedge clk);
      wr(CH0_GAIN_CAL_HIGH_OFS, 16'h5678);
      rd(CH0_GAIN_CAL_HIGH_OFS, 16'h5678);
      wr(CH0_GAIN_CAL_LOW_OFS, 16'h9AAB);
      wr(CH1_OFFSET_CAL_LOW_OFS, 16'h80FF);
      wr(CH1_OFFSET_CAL_HIGH_OFS, 16'h8000);
      wr(CH1_GAIN_CAL_HIGH_OFS, 16'h0000);
      wr(CH1_GAIN_CAL_LOW_OFS, 16'h0100);
      idle(2);
      @(negedge clk);
      cmp24(g0, 24'h56789A);
      cmp24(of1, 24'h800080);
      cmp24(g1, 24'h000001);
      @(posedge clk);
   endtask
   task automatic t_sel;
      for (int s = 0; s < 4; s++)
      begin
         wr(CH1_INPUT_CONFIG_OFS, {14'h0, 2'(s)});
         rd(CH1_INPUT_CONFIG_OFS, {14'h0, 2'(s)});
         idle(1);
         @(negedge clk);
         cmp16({10'h0, sel, tn, tp, sh, pc}, {10'h0, 2'(s), 4'h1 << s});
         @(posedge clk);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_mask();
      t_pair();
      t_sel();
      idle(2);
      final_report();
   end
endmodule
`default_nettype wire
